// *** iep_pkg.sv ***
// interrupt enable and priority register constants, types and helpers
// assumes a 16-bit register port and one system clock
// What this block does
// - an enable bit at one forwards its source's pending request; zero holds it back
// - unassigned bits of enable and priority registers ignore writes and read zero
// - priority fields are three bits, value is level; 111 is level 7, highest
// - field 001 is level 1, lowest serviced; patterns between map to levels 2-6
// - field 000 disables its source whatever its enable bit or flag
// - first enable register: capture 1 at bit 1, external pin 0 at bit 0
// - second enable register: pin2 13, pin1 4, change 3, comparator 2, i2c 1/0
// - third enable register holds only capture 3 at bit 5, rest reads zero
// - fourth enable register holds pulse modulator at bit 9, bits 15-10 read zero
// - fifth enable register: capacitive measure bit 13, serial error bit 1, rest zero
// - first priority register: timer1 14-12, compare1 10-8, capture1 6-4, pin0 2-0
// - second priority register: timer2 14-12, compare2 10-8; bits 15 and 11 zero
// - first enable register also enables converter, serial, spi, timers, compare, capture
// - first enable register bits sit at the flag positions, converter at bit 13
// - each source flag is set on its request; enable qualifies it, priority also for the six prioritised sources
package iep_pkg;

    // =========================================
    // register addresses (word index)
    localparam logic [3:0] ADDR_INT_ENABLE_CTL_0 = 4'h0;
    localparam logic [3:0] ADDR_INT_ENABLE_CTL_1 = 4'h1;
    localparam logic [3:0] ADDR_INT_ENABLE_CTL_2 = 4'h2;
    localparam logic [3:0] ADDR_INT_ENABLE_CTL_3 = 4'h3;
    localparam logic [3:0] ADDR_INT_ENABLE_CTL_4 = 4'h4;
    localparam logic [3:0] ADDR_INT_PRIORITY_CTL_0 = 4'h5;
    localparam logic [3:0] ADDR_INT_PRIORITY_CTL_1 = 4'h6;
    localparam logic [3:0] ADDR_STS = 4'h8;
    localparam logic [3:0] ADDR_MSK = 4'h9;

    // =========================================
    // implemented bit masks, reset values
    // bank0: conv 13, tx 12, rx 11, spi 10, spi fault 9, t3 8, t2 7, oc2 6, ic2 5,
    // t1 3, oc1 2, ic1 1, pin0 0
    localparam logic [4:0][15:0] EN_MASK = {16'h2002, 16'h0200, 16'h0020, 16'h201F, 16'h3FEF};
    localparam logic [1:0][15:0] PRI_MASK = {16'h7700, 16'h7777};
    localparam logic [1:0][15:0] PRI_RST = {16'h4400, 16'h4444};
    localparam logic [15:0] STS_MASK = 16'h001F;
    localparam logic [2:0] LVL_OFF = 3'h0;

    // =========================================
    // prioritised sources: pin0, capture1, compare1, timer1, compare2, timer2
    localparam int NSRC = 6;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_PIN0 = 0;
    localparam logic [5:0][3:0] SRC_LSB = {4'hC, 4'h8, 4'hC, 4'h8, 4'h4, 4'h0};
    localparam logic [5:0][3:0] SRC_EN_BIT = {4'h7, 4'h6, 4'h3, 4'h2, 4'h1, 4'h0};
    localparam logic [5:0] SRC_PRI_REG = 6'h30;

    // =========================================
    // state
    typedef struct packed {
        logic [4:0][15:0] en;
        logic [1:0][15:0] pri;
        logic [4:0][15:0] req;
        logic [5:0][2:0] lvl;
        logic [4:0] sts;
        logic [4:0] msk;
        logic [15:0] rdata;
        logic irq;
    } iep_state_t;

    localparam iep_state_t ST_RST = '{en: '0, pri: PRI_RST, req: '0, lvl: '0,
        sts: '0, msk: '0, rdata: '0, irq: 1'b0};

    // =========================================
    // helpers
    function automatic logic [2:0] iep_field(input logic [15:0] r, input logic [3:0] lsb);
        iep_field = r[lsb +: 3];
    endfunction

    function automatic logic [15:0] iep_addr_mask(input logic [3:0] a);
        case (a)
            ADDR_INT_ENABLE_CTL_0: iep_addr_mask = EN_MASK[0];
            ADDR_INT_ENABLE_CTL_1: iep_addr_mask = EN_MASK[1];
            ADDR_INT_ENABLE_CTL_2: iep_addr_mask = EN_MASK[2];
            ADDR_INT_ENABLE_CTL_3: iep_addr_mask = EN_MASK[3];
            ADDR_INT_ENABLE_CTL_4: iep_addr_mask = EN_MASK[4];
            ADDR_INT_PRIORITY_CTL_0: iep_addr_mask = PRI_MASK[0];
            ADDR_INT_PRIORITY_CTL_1: iep_addr_mask = PRI_MASK[1];
            ADDR_STS: iep_addr_mask = STS_MASK;
            ADDR_MSK: iep_addr_mask = STS_MASK;
            default: iep_addr_mask = 16'h0000;
        endcase
    endfunction

endpackage

// *** iep_regs.sv ***
// interrupt enable and priority registers with request qualification
// assumes flags arrive synchronous to i_mclk in the flag-register bit layout
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module iep_regs
    import iep_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // request flags from peripherals
    input wire logic [15:0] i_flag_0,
    input wire logic [15:0] i_flag_1,
    input wire logic [15:0] i_flag_2,
    input wire logic [15:0] i_flag_3,
    input wire logic [15:0] i_flag_4,
    // qualified requests to arbitration
    output logic [15:0] o_req_0,
    output logic [15:0] o_req_1,
    output logic [15:0] o_req_2,
    output logic [15:0] o_req_3,
    output logic [15:0] o_req_4,
    // presented levels
    output logic [2:0] o_lvl_ext_pin0,
    output logic [2:0] o_lvl_capture1,
    output logic [2:0] o_lvl_compare1,
    output logic [2:0] o_lvl_timer1,
    output logic [2:0] o_lvl_compare2,
    output logic [2:0] o_lvl_timer2,
    // interrupt
    output logic o_irq
);

    // =========================================
    // reset release
    logic rst_meta_r;
    logic rst_n_s;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s <= rst_meta_r;
        end
    end

    // =========================================
    // state
    iep_state_t st_r;
    iep_state_t st_nxt;
    logic [4:0][15:0] flag;
    logic [4:0] clr;
    logic [4:0] ev;
    logic [2:0] fld;

    assign flag = {i_flag_4, i_flag_3, i_flag_2, i_flag_1, i_flag_0};

    always_comb begin
        st_nxt = st_r;
        clr = '0;
        ev = '0;
        fld = LVL_OFF;
        // register writes, unassigned bits masked off
        if (i_wr) begin
            case (i_addr)
                ADDR_INT_ENABLE_CTL_0: st_nxt.en[0] = i_wdata & EN_MASK[0];
                ADDR_INT_ENABLE_CTL_1: st_nxt.en[1] = i_wdata & EN_MASK[1];
                ADDR_INT_ENABLE_CTL_2: st_nxt.en[2] = i_wdata & EN_MASK[2];
                ADDR_INT_ENABLE_CTL_3: st_nxt.en[3] = i_wdata & EN_MASK[3];
                ADDR_INT_ENABLE_CTL_4: st_nxt.en[4] = i_wdata & EN_MASK[4];
                ADDR_INT_PRIORITY_CTL_0: st_nxt.pri[0] = i_wdata & PRI_MASK[0];
                ADDR_INT_PRIORITY_CTL_1: st_nxt.pri[1] = i_wdata & PRI_MASK[1];
                ADDR_STS: clr = i_wdata[4:0];
                ADDR_MSK: st_nxt.msk = i_wdata[4:0];
                default: clr = '0;
            endcase
        end
        // read data, one cycle after the strobe
        st_nxt.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                ADDR_INT_ENABLE_CTL_0: st_nxt.rdata = st_r.en[0];
                ADDR_INT_ENABLE_CTL_1: st_nxt.rdata = st_r.en[1];
                ADDR_INT_ENABLE_CTL_2: st_nxt.rdata = st_r.en[2];
                ADDR_INT_ENABLE_CTL_3: st_nxt.rdata = st_r.en[3];
                ADDR_INT_ENABLE_CTL_4: st_nxt.rdata = st_r.en[4];
                ADDR_INT_PRIORITY_CTL_0: st_nxt.rdata = st_r.pri[0];
                ADDR_INT_PRIORITY_CTL_1: st_nxt.rdata = st_r.pri[1];
                ADDR_STS: st_nxt.rdata = {11'h000, st_r.sts};
                ADDR_MSK: st_nxt.rdata = {11'h000, st_r.msk};
                default: st_nxt.rdata = '0;
            endcase
        end
        // flag qualified by enable
        for (int k = 0; k < 5; k++) begin
            st_nxt.req[k] = flag[k] & st_r.en[k];
        end
        // priority gate and level
        for (int s = 0; s < NSRC; s++) begin
            fld = iep_field(st_r.pri[SRC_PRI_REG[s]], SRC_LSB[s]);
            if (fld == LVL_OFF) begin
                st_nxt.req[0][SRC_EN_BIT[s]] = 1'b0;
            end
            st_nxt.lvl[s] = st_nxt.req[0][SRC_EN_BIT[s]] ? fld : LVL_OFF;
        end
        // new presentation per bank sets a sticky bit; set beats clear
        for (int k = 0; k < 5; k++) begin
            ev[k] = |(st_nxt.req[k] & ~st_r.req[k]);
        end
        st_nxt.sts = (st_r.sts & ~clr) | ev;
        st_nxt.irq = |(st_nxt.sts & st_nxt.msk);
    end

    always_ff @(posedge i_mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =========================================
    // outputs
    assign o_rdata = st_r.rdata;
    assign o_req_0 = st_r.req[0];
    assign o_req_1 = st_r.req[1];
    assign o_req_2 = st_r.req[2];
    assign o_req_3 = st_r.req[3];
    assign o_req_4 = st_r.req[4];
    assign o_lvl_ext_pin0 = st_r.lvl[0];
    assign o_lvl_capture1 = st_r.lvl[1];
    assign o_lvl_compare1 = st_r.lvl[2];
    assign o_lvl_timer1 = st_r.lvl[3];
    assign o_lvl_compare2 = st_r.lvl[4];
    assign o_lvl_timer2 = st_r.lvl[5];
    assign o_irq = st_r.irq;

    // =========================================
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n_s);

    localparam logic [3:0] T1_BIT = SRC_EN_BIT[SRC_TIMER1];
    localparam logic [3:0] T1_LSB = SRC_LSB[SRC_TIMER1];

    a_en_blocks_req: assert property (
        1'b1 |=> (o_req_2 & ~$past(st_r.en[2])) == 16'h0000 &&
            (o_req_0 & ~$past(st_r.en[0])) == 16'h0000)
        else $error("request passed with enable low");

    a_flag_en_pass: assert property (
        1'b1 |=> o_req_1 == ($past(i_flag_1) & $past(st_r.en[1])))
        else $error("enabled flag not forwarded");

    a_unimpl_read: assert property (
        i_rd |=> (o_rdata & ~iep_addr_mask($past(i_addr))) == 16'h0000)
        else $error("unassigned bit read nonzero");

    a_unimpl_write: assert property (
        i_wr && i_addr == ADDR_INT_ENABLE_CTL_4 |=> st_r.en[4] == ($past(i_wdata) & EN_MASK[4]))
        else $error("enable write not masked");

    a_zero_prio_off: assert property (
        iep_field(st_r.pri[0], T1_LSB) == LVL_OFF |=> !o_req_0[T1_BIT] && o_lvl_timer1 == 3'h0)
        else $error("source with priority zero presented");

    a_lvl_matches: assert property (
        1'b1 |=> o_req_0[T1_BIT] ?
            o_lvl_timer1 == $past(st_r.pri[0][14:12]) : o_lvl_timer1 == 3'h0)
        else $error("presented level wrong");

    a_reset_values: assert property (
        $rose(rst_n_s) |-> st_r.pri[0] == 16'h4444 && st_r.pri[1] == 16'h4400 &&
            st_r.en == '0)
        else $error("reset values wrong");

    a_pin0_bit: assert property (
        i_wr && i_addr == ADDR_INT_ENABLE_CTL_0 && i_wdata[0] && i_flag_0[0] ##1
            i_flag_0[0] && !(i_wr && i_addr == ADDR_INT_PRIORITY_CTL_0) && st_r.pri[0][2:0] != 3'h0
            |=> o_req_0[0] && o_lvl_ext_pin0 == $past(st_r.pri[0][2:0]))
        else $error("pin0 enable at bit 0 not effective");

    a_irq_level: assert property (
        o_irq == |(st_r.sts & st_r.msk))
        else $error("interrupt output disagrees with status and mask");

    a_set_wins: assert property (
        i_wr && i_addr == ADDR_STS && i_wdata[1] && (i_flag_1 & st_r.en[1] & ~o_req_1) != 0
            |=> st_r.sts[1])
        else $error("event lost under clear");

    // =========================================
    // enable gating per bank
    a_bank1_gate: assert property (
        1'b1 |=> (o_req_1 & ~$past(st_r.en[1])) == 16'h0000)
        else $error("bank 1 request passed with enable low");

    a_bank3_gate: assert property (
        1'b1 |=> (o_req_3 & ~$past(st_r.en[3])) == 16'h0000)
        else $error("bank 3 request passed with enable low");

    a_bank4_gate: assert property (
        1'b1 |=> (o_req_4 & ~$past(st_r.en[4])) == 16'h0000)
        else $error("bank 4 request passed with enable low");

    a_bank2_pass: assert property (
        1'b1 |=> o_req_2 == ($past(i_flag_2) & $past(st_r.en[2])))
        else $error("bank 2 flag not forwarded");

    a_bank3_pass: assert property (
        1'b1 |=> o_req_3 == ($past(i_flag_3) & $past(st_r.en[3])))
        else $error("bank 3 flag not forwarded");

    a_bank4_pass: assert property (
        1'b1 |=> o_req_4 == ($past(i_flag_4) & $past(st_r.en[4])))
        else $error("bank 4 flag not forwarded");

    // =========================================
    // register writes
    a_int_enable_ctl_0_write: assert property (
        i_wr && i_addr == ADDR_INT_ENABLE_CTL_0 |=> st_r.en[0] == ($past(i_wdata) & EN_MASK[0]))
        else $error("first enable write wrong");

    a_int_enable_ctl_1_write: assert property (
        i_wr && i_addr == ADDR_INT_ENABLE_CTL_1 |=> st_r.en[1] == ($past(i_wdata) & EN_MASK[1]))
        else $error("second enable write wrong");

    a_int_enable_ctl_2_write: assert property (
        i_wr && i_addr == ADDR_INT_ENABLE_CTL_2 |=> st_r.en[2] == ($past(i_wdata) & EN_MASK[2]))
        else $error("third enable write wrong");

    a_int_enable_ctl_3_write: assert property (
        i_wr && i_addr == ADDR_INT_ENABLE_CTL_3 |=> st_r.en[3] == ($past(i_wdata) & EN_MASK[3]))
        else $error("fourth enable write wrong");

    a_int_priority_ctl_0_write: assert property (
        i_wr && i_addr == ADDR_INT_PRIORITY_CTL_0 |=> st_r.pri[0] == ($past(i_wdata) & PRI_MASK[0]))
        else $error("first priority write wrong");

    a_int_priority_ctl_1_write: assert property (
        i_wr && i_addr == ADDR_INT_PRIORITY_CTL_1 |=> st_r.pri[1] == ($past(i_wdata) & PRI_MASK[1]))
        else $error("second priority write wrong");

    a_en_hold: assert property (
        !(i_wr && i_addr <= ADDR_INT_ENABLE_CTL_4) |=> $stable(st_r.en))
        else $error("enables changed without a write");

    a_pri_hold: assert property (
        !(i_wr && (i_addr == ADDR_INT_PRIORITY_CTL_0 || i_addr == ADDR_INT_PRIORITY_CTL_1)) |=> $stable(st_r.pri))
        else $error("priorities changed without a write");

    a_msk_write: assert property (
        i_wr && i_addr == ADDR_MSK |=> st_r.msk == $past(i_wdata[4:0]))
        else $error("mask write wrong");

    // =========================================
    // register reads
    a_int_enable_ctl_0_read: assert property (
        i_rd && i_addr == ADDR_INT_ENABLE_CTL_0 |=> o_rdata == $past(st_r.en[0]))
        else $error("first enable read wrong");

    a_int_enable_ctl_1_read: assert property (
        i_rd && i_addr == ADDR_INT_ENABLE_CTL_1 |=> o_rdata == $past(st_r.en[1]))
        else $error("second enable read wrong");

    a_int_enable_ctl_2_read: assert property (
        i_rd && i_addr == ADDR_INT_ENABLE_CTL_2 |=> o_rdata == $past(st_r.en[2]))
        else $error("third enable read wrong");

    a_int_enable_ctl_3_read: assert property (
        i_rd && i_addr == ADDR_INT_ENABLE_CTL_3 |=> o_rdata == $past(st_r.en[3]))
        else $error("fourth enable read wrong");

    a_int_enable_ctl_4_read: assert property (
        i_rd && i_addr == ADDR_INT_ENABLE_CTL_4 |=> o_rdata == $past(st_r.en[4]))
        else $error("fifth enable read wrong");

    a_int_priority_ctl_0_read: assert property (
        i_rd && i_addr == ADDR_INT_PRIORITY_CTL_0 |=> o_rdata == $past(st_r.pri[0]))
        else $error("first priority read wrong");

    a_int_priority_ctl_1_read: assert property (
        i_rd && i_addr == ADDR_INT_PRIORITY_CTL_1 |=> o_rdata == $past(st_r.pri[1]))
        else $error("second priority read wrong");

    a_sts_read: assert property (
        i_rd && i_addr == ADDR_STS |=> o_rdata == {11'h000, $past(st_r.sts)})
        else $error("status read wrong");

    a_rdata_idle: assert property (
        !i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside its cycle");

    // =========================================
    // presented levels
    a_lvl_pin0: assert property (
        1'b1 |=> o_req_0[SRC_EN_BIT[0]] ?
            o_lvl_ext_pin0 == iep_field($past(st_r.pri[0]), SRC_LSB[0]) :
            o_lvl_ext_pin0 == LVL_OFF)
        else $error("pin 0 level wrong");

    a_lvl_capture1: assert property (
        1'b1 |=> o_req_0[SRC_EN_BIT[1]] ?
            o_lvl_capture1 == iep_field($past(st_r.pri[0]), SRC_LSB[1]) :
            o_lvl_capture1 == LVL_OFF)
        else $error("capture 1 level wrong");

    a_lvl_compare1: assert property (
        1'b1 |=> o_req_0[SRC_EN_BIT[2]] ?
            o_lvl_compare1 == iep_field($past(st_r.pri[0]), SRC_LSB[2]) :
            o_lvl_compare1 == LVL_OFF)
        else $error("compare 1 level wrong");

    a_lvl_compare2: assert property (
        1'b1 |=> o_req_0[SRC_EN_BIT[4]] ?
            o_lvl_compare2 == iep_field($past(st_r.pri[1]), SRC_LSB[4]) :
            o_lvl_compare2 == LVL_OFF)
        else $error("compare 2 level wrong");

    a_lvl_timer2: assert property (
        1'b1 |=> o_req_0[SRC_EN_BIT[5]] ?
            o_lvl_timer2 == iep_field($past(st_r.pri[1]), SRC_LSB[5]) :
            o_lvl_timer2 == LVL_OFF)
        else $error("timer 2 level wrong");

    // =========================================
    // priority zero turns a source off
    a_off_pin0: assert property (
        iep_field(st_r.pri[0], SRC_LSB[0]) == LVL_OFF |=> !o_req_0[SRC_EN_BIT[0]])
        else $error("pin 0 presented at priority zero");

    a_off_capture1: assert property (
        iep_field(st_r.pri[0], SRC_LSB[1]) == LVL_OFF |=> !o_req_0[SRC_EN_BIT[1]])
        else $error("capture 1 presented at priority zero");

    a_off_compare1: assert property (
        iep_field(st_r.pri[0], SRC_LSB[2]) == LVL_OFF |=> !o_req_0[SRC_EN_BIT[2]])
        else $error("compare 1 presented at priority zero");

    a_off_compare2: assert property (
        iep_field(st_r.pri[1], SRC_LSB[4]) == LVL_OFF |=> !o_req_0[SRC_EN_BIT[4]])
        else $error("compare 2 presented at priority zero");

    a_off_timer2: assert property (
        iep_field(st_r.pri[1], SRC_LSB[5]) == LVL_OFF |=> !o_req_0[SRC_EN_BIT[5]])
        else $error("timer 2 presented at priority zero");

    // =========================================
    // status, mask and reset
    a_sts_clear: assert property (
        i_wr && i_addr == ADDR_STS && i_wdata[0] &&
            (i_flag_0 & st_r.en[0] & ~o_req_0) == 16'h0000 |=> !st_r.sts[0])
        else $error("status bit not cleared");

    a_sts_sticky: assert property (
        st_r.sts[2] && !(i_wr && i_addr == ADDR_STS && i_wdata[2]) |=> st_r.sts[2])
        else $error("status bit lost");

    a_sts_event: assert property (
        (i_flag_2 & st_r.en[2] & ~o_req_2) != 16'h0000 |=> st_r.sts[2])
        else $error("new request did not set status");

    a_irq_masked: assert property (
        st_r.msk == 5'h00 |-> !o_irq)
        else $error("interrupt with all sources masked");

    a_reset_outputs: assert property (
        $rose(rst_n_s) |-> !o_irq && o_rdata == 16'h0000 && o_req_0 == 16'h0000)
        else $error("outputs not idle after reset");

    c_top_level: cover property (o_lvl_timer1 == 3'h7);
    c_w1c: cover property (i_wr && i_addr == ADDR_STS && st_r.sts != 5'h00);
    c_irq: cover property (o_irq ##1 !o_irq);
    c_pin0_top: cover property (o_lvl_ext_pin0 == 3'h7);
    c_prio_off: cover property (o_req_0 == 16'h3F20);

endmodule // iep_regs

// *** iep_src_model.sv ***
// peripheral request source model: sticky flags in the flag-register layout
// assumes the bench raises bits for one cycle and drops all flags with i_drop
`timescale 1ns/10ps
module iep_src_model (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // requests from the bench
    input wire logic [4:0][15:0] i_raise,
    input wire logic i_drop,
    // flags to the block
    output logic [4:0][15:0] o_flag
);
    // =========================================
    // flags stay set until dropped
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_flag <= '0;
        end else begin
            o_flag <= i_drop ? '0 : (o_flag | i_raise);
        end
    end
endmodule // iep_src_model

// *** tb_top.sv ***
// self-checking bench for the enable and priority registers
// assumes the register port timing and index map of the block package
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top;
    import iep_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] addr = '0;
    logic [15:0] wdata = '0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic drop = 1'b0;
    logic [4:0][15:0] raise = '0;
    logic [4:0][15:0] flag;
    logic [4:0][15:0] req;
    logic [5:0][2:0] lvl;
    logic [15:0] rdata;
    logic irq;
    int mismatches = 0;
    int checks_done = 0;
    logic [15:0] exp_rst [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h4444, 16'h4400};
    logic [15:0] exp_one [7] = '{16'h3FEF, 16'h201F, 16'h0020, 16'h0200, 16'h2002,
        16'h7777, 16'h7700};
    // =========================================
    // clock, design and partner
    always #2.5 i_mclk = ~i_mclk;
    iep_src_model i_iep_src_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_raise(raise),
        .i_drop(drop), .o_flag(flag));
    iep_regs i_iep_regs (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
        .i_flag_0(flag[0]), .i_flag_1(flag[1]), .i_flag_2(flag[2]), .i_flag_3(flag[3]),
        .i_flag_4(flag[4]), .o_req_0(req[0]), .o_req_1(req[1]), .o_req_2(req[2]),
        .o_req_3(req[3]), .o_req_4(req[4]), .o_lvl_ext_pin0(lvl[0]),
        .o_lvl_capture1(lvl[1]), .o_lvl_compare1(lvl[2]), .o_lvl_timer1(lvl[3]),
        .o_lvl_compare2(lvl[4]), .o_lvl_timer2(lvl[5]), .o_irq(irq));
    // =========================================
    // bus and flag tasks
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdata <= d;
        bus_wr <= 1'b1;
        @(posedge i_mclk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string n);
        @(posedge i_mclk);
        addr <= a;
        bus_rd <= 1'b1;
        @(posedge i_mclk);
        bus_rd <= 1'b0;
        #1;
        `CHK(n, e, rdata)
    endtask
    task automatic pulse_flags(input logic [4:0][15:0] v, input logic d);
        @(posedge i_mclk);
        raise <= v;
        drop <= d;
        @(posedge i_mclk);
        raise <= '0;
        drop <= 1'b0;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask
    // =========================================
    // scenarios
    task automatic t_reset_and_fields();
        for (int a = 0; a < 7; a++) rd_chk(4'(a), exp_rst[a], "reset value");
        for (int a = 0; a < 7; a++) begin
            wr(4'(a), 16'hFFFF);
            rd_chk(4'(a), exp_one[a], "implemented bits");
        end
        wr(4'h7, 16'hFFFF);
        rd_chk(4'h7, 16'h0000, "unmapped read");
    endtask
    task automatic t_gating();
        pulse_flags({5{16'hFFFF}}, 1'b0);
        for (int k = 0; k < 5; k++) `CHK("enabled request", exp_one[k], req[k])
        for (int l = 0; l < 8; l++) begin
            wr(ADDR_INT_PRIORITY_CTL_0, {1'b0, 3'(l), 1'b0, 3'(l), 1'b0, 3'(l), 1'b0, 3'(l)});
            wr(ADDR_INT_PRIORITY_CTL_1, {1'b0, 3'(l), 1'b0, 3'(l), 8'h00});
            repeat (2) @(posedge i_mclk);
            #1;
            `CHK("level", {6{3'(l)}}, lvl)
            `CHK("bank0 request", (l == 0) ? 16'h3F20 : 16'h3FEF, req[0])
        end
        wr(ADDR_INT_ENABLE_CTL_0, 16'h0000);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK("disabled request", 16'h0000, req[0])
        `CHK("disabled level", 18'h0, lvl)
    endtask
    task automatic t_interrupt();
        pulse_flags('0, 1'b1);
        wr(ADDR_STS, 16'h001F);
        rd_chk(ADDR_STS, 16'h0000, "status cleared");
        wr(ADDR_MSK, 16'h0001);
        pulse_flags({64'h0, 16'h0001}, 1'b0);
        `CHK("held back", 16'h0000, req[0])
        wr(ADDR_INT_ENABLE_CTL_0, 16'h0001);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK("irq raised", 1'b1, irq)
        `CHK("pin0 level", 3'h7, lvl[0])
        rd_chk(ADDR_STS, 16'h0001, "status set");
        wr(ADDR_MSK, 16'h0000);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK("irq masked", 1'b0, irq)
        wr(ADDR_MSK, 16'h0001);
        wr(ADDR_STS, 16'h0001);
        repeat (2) @(posedge i_mclk);
        #1;
        `CHK("irq cleared", 1'b0, irq)
    endtask
    // =========================================
    // verdict and sequence
    task automatic summarize();
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        t_reset_and_fields();
        t_gating();
        t_interrupt();
        summarize();
    end
endmodule // tb_top
